//--- rtl/parallel_port_pkg.sv
// Constants and types of the parallel port service-request block.
//
// Operation
// - Status register holds a service bit and a live level bit per handshake pin.
// - Interrupt per pin: status, enable, and no DMA association on first pins; ORed.
// - Interrupt request reaches the shared C5 pin only when that function is selected.
// - DMA requests keep buffers empty or full and never overrun the controller.
// - Acknowledge drives vector: upper six bits from vector register, lower two from priority.
// - Priority picks highest enabled active source not tied to DMA.
// - Acknowledge cycles only drive the vector and change no state.
// - Without interrupt function or pending request, acknowledge is ignored, no transfer acknowledge.
// - Vector register unwritten since reset returns 0F on acknowledge.
// - Priority codes: A first 00, A second 01, B first 10, B second 11.
// - Autovectored operation supplies no vector and leaves the acknowledge pin unused.
// - Edge status flops are set by the asserted edge of their pin.
// - Status write clears resettable bits where mask is one; others unaffected.
// - Four sense bits XOR every handshake pin; reset makes low asserted.
// - General control holds pair A and pair B enables, cleared by reset.
// - Disabled pair holds its handshake controller empty.
// - Disabled pair holds simple status flops at zero.
// - Disabled pair holds interlocked or pulsed second pin negated.
// - Two read-only alternate registers return live port pin levels without side effects.
// - Mode 0 ports independent: submode 00 input, 01 output, 1X bit I/O.
// - Pair A belongs to port A control and enable; pair B likewise to port B.
// - Direction bits select read source per submode; output submode writes double-buffered.
package parallel_port_pkg;

  localparam logic [7:0] ADDR_GENERAL = 8'h00;
  localparam logic [7:0] ADDR_REQUEST = 8'h04;
  localparam logic [7:0] ADDR_VECTOR = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CTRL_A = 8'h10;
  localparam logic [7:0] ADDR_CTRL_B = 8'h14;
  localparam logic [7:0] ADDR_DIR_A = 8'h18;
  localparam logic [7:0] ADDR_DIR_B = 8'h1C;
  localparam logic [7:0] ADDR_DATA_A = 8'h20;
  localparam logic [7:0] ADDR_DATA_B = 8'h24;
  localparam logic [7:0] ADDR_ALT_A = 8'h28;
  localparam logic [7:0] ADDR_ALT_B = 8'h2C;

  // General control: sense bits 3:0, pair enables 4 and 5.
  localparam int GEN_EN_A = 4;
  // Request control: interrupt function 0, vectored acknowledge 1, DMA enable 2, DMA on port B 3.
  localparam int REQ_IRQ_SEL = 0;
  localparam int REQ_ACK_SEL = 1;
  localparam int REQ_DMA_ON = 2;
  localparam int REQ_DMA_PORT = 3;
  // Port control: status control 0, first enable 1, second enable 2, second pin mode 5:3, submode 7:6.
  localparam int CTL_H1S_ALL = 0;
  localparam int CTL_IE_FIRST = 1;
  localparam int CTL_IE_SECOND = 2;
  localparam int CTL_H2_LSB = 3;
  localparam int CTL_SUB_LSB = 6;

  localparam logic [1:0] SUB_IN = 2'h0;
  localparam logic [1:0] SUB_OUT = 2'h1;
  localparam logic [2:0] H2_NEGATED = 3'h4;
  localparam logic [2:0] H2_ASSERTED = 3'h5;
  localparam logic [2:0] H2_INTERLOCK = 3'h6;
  localparam logic [2:0] H2_PULSED = 3'h7;

  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_FULL = 2'h2;
  localparam logic [2:0] PULSE_CYCLES = 3'h4;
  localparam logic [7:0] VECTOR_UNINIT = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic [1:0] cnt;
    logic [7:0] final_output_latch;
    logic [7:0] initial_output_latch;
    logic [7:0] final_input_latch;
    logic [7:0] iil;
    logic h1sFlag;
    logic h2sFlag;
    logic [2:0] pulseCnt;
  } portState_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } portDrive_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pinDrive_t;

  typedef struct packed {
    portState_t [1:0] port;
    logic [7:0] gen;
    logic [7:0] req;
    logic [7:0] vec;
    logic vecInit;
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] dir;
    logic [3:0] hsMeta;
    logic [3:0] hsSync;
    logic [3:0] hsPrev;
    logic [1:0][7:0] pinMeta;
    logic [1:0][7:0] pinSync;
    logic ackMeta;
    logic ackSync;
    logic ackPrev;
    logic ackActive;
    logic [7:0] vecOut;
    logic dmaPending;
    logic [31:0] hrdata;
    logic wrPend;
    logic [7:0] wrAddr;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage : parallel_port_pkg

//--- rtl/parallel_port_service_request.sv
// Mode 0 parallel port pair with status, sense, enables, DMA and vectored interrupt logic.
`timescale 1ns/100ps
module parallel_port_service_request
  import parallel_port_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic handshakeAFirst,
  input wire logic handshakeASecondIn,
  output pinDrive_t handshakeASecond,
  input wire logic handshakeBFirst,
  input wire logic handshakeBSecondIn,
  output pinDrive_t handshakeBSecond,
  input wire logic [7:0] portAIn,
  output portDrive_t portAOut,
  input wire logic [7:0] portBIn,
  output portDrive_t portBOut,
  output logic sharedC5InterruptPin,
  output logic sharedC5InterruptOe,
  output logic sharedC4DmaPin,
  output logic sharedC4DmaOe,
  input wire logic sharedC6AcknowledgePinN,
  output logic [7:0] vectorData,
  output logic vectorOe,
  output logic transferAck
);

  state_t s_q;
  state_t s_d;

  function automatic logic isEdgeInput(input logic [2:0] mode);
    isEdgeInput = ~mode[2];
  endfunction : isEdgeInput

  function automatic logic isLinked(input logic [2:0] mode);
    isLinked = (mode == H2_INTERLOCK) || (mode == H2_PULSED);
  endfunction : isLinked

  logic [3:0] asserted;
  logic [3:0] edgeSeen;
  logic [3:0] status;
  logic [3:0] resettable;
  logic [3:0] intReq;
  logic [1:0] h2Out;
  logic [1:0] h2Oe;
  logic [1:0] prioCode;
  logic irqActive;
  logic port_dma_request;
  logic addrRead;
  logic [7:0] rdAddr;
  logic [7:0] rdByte;
  logic [1:0] dataRead;
  logic [1:0] dataWrite;
  logic statusWrite;
  logic [7:0] wrByte;

  // Sense bits flip each pin so that internal logic always sees active-high assertion.
  always_comb
  begin
    asserted = s_q.hsSync ^ ~s_q.gen[3:0];
    edgeSeen = asserted & ~s_q.hsPrev;
  end

  // Status, clear mask and second pin drive per pair.
  always_comb
  begin
    status = '0;
    resettable = '0;
    h2Out = '0;
    h2Oe = '0;
    for (int p = 0; p < 2; p++)
    begin
      logic en;
      logic [1:0] sub;
      logic [2:0] h2m;
      logic ready;
      en = s_q.gen[GEN_EN_A + p];
      sub = s_q.ctrl[p][CTL_SUB_LSB +: 2];
      h2m = s_q.ctrl[p][CTL_H2_LSB +: 3];
      ready = 1'b0;
      if (sub[1])
      begin
        status[2 * p] = s_q.port[p].h1sFlag;
        resettable[2 * p] = 1'b1;
      end
      else if (sub == SUB_IN)
      begin
        status[2 * p] = s_q.port[p].cnt != CNT_EMPTY;
        ready = s_q.port[p].cnt != CNT_FULL;
      end
      else
      begin
        status[2 * p] = s_q.ctrl[p][CTL_H1S_ALL] ? (s_q.port[p].cnt == CNT_EMPTY) : (s_q.port[p].cnt != CNT_FULL);
        ready = s_q.port[p].cnt != CNT_EMPTY;
      end
      if (isEdgeInput(h2m))
      begin
        status[2 * p + 1] = s_q.port[p].h2sFlag;
        resettable[2 * p + 1] = 1'b1;
      end
      else
      begin
        h2Oe[p] = 1'b1;
        if (h2m == H2_ASSERTED)
        begin
          h2Out[p] = 1'b1;
        end
        // Linked handshakes are unavailable in bit I/O, so the pin stays negated there.
        else if (isLinked(h2m) && en && !sub[1])
        begin
          h2Out[p] = ready && !edgeSeen[2 * p] && (h2m != H2_PULSED || s_q.port[p].pulseCnt < PULSE_CYCLES);
        end
      end
    end
  end

  // DMA takes the first pin of one pair; that pin then raises no interrupt.
  always_comb
  begin
    logic assoc;
    logic sub1;
    assoc = s_q.req[REQ_DMA_PORT];
    sub1 = s_q.ctrl[assoc][CTL_SUB_LSB + 1];
    // One request per service need; the next waits until the port is accessed.
    port_dma_request = s_q.req[REQ_DMA_ON] && !sub1 && status[2 * assoc] && !s_q.dmaPending;
    for (int i = 0; i < 4; i++)
    begin
      logic ieBit;
      ieBit = s_q.ctrl[i / 2][(i % 2 == 0) ? CTL_IE_FIRST : CTL_IE_SECOND];
      intReq[i] = status[i] && ieBit;
      if (i % 2 == 0 && s_q.req[REQ_DMA_ON] && (i / 2) == int'(assoc))
      begin
        intReq[i] = 1'b0;
      end
    end
    irqActive = |intReq;
    prioCode = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (intReq[i])
      begin
        prioCode = 2'(i);
      end
    end
  end

  // Bus decode; reads are served from the address phase so read data leaves a flop with no wait state.
  always_comb
  begin
    logic idx;
    logic [7:0] src;
    idx = 1'b0;
    src = REG_RESET;
    addrRead = hsel && htrans[1] && !hwrite && hready;
    rdAddr = haddr[7:0];
    wrByte = hwdata[7:0];
    dataRead[0] = addrRead && rdAddr == ADDR_DATA_A;
    dataRead[1] = addrRead && rdAddr == ADDR_DATA_B;
    dataWrite[0] = s_q.wrPend && s_q.wrAddr == ADDR_DATA_A;
    dataWrite[1] = s_q.wrPend && s_q.wrAddr == ADDR_DATA_B;
    statusWrite = s_q.wrPend && s_q.wrAddr == ADDR_STATUS;
    rdByte = REG_RESET;
    unique case (rdAddr)
      ADDR_GENERAL: rdByte = s_q.gen;
      ADDR_REQUEST: rdByte = s_q.req;
      ADDR_VECTOR: rdByte = s_q.vecInit ? s_q.vec : VECTOR_UNINIT;
      ADDR_STATUS: rdByte = {asserted, status};
      ADDR_CTRL_A: rdByte = s_q.ctrl[0];
      ADDR_CTRL_B: rdByte = s_q.ctrl[1];
      ADDR_DIR_A: rdByte = s_q.dir[0];
      ADDR_DIR_B: rdByte = s_q.dir[1];
      ADDR_ALT_A: rdByte = s_q.pinSync[0];
      ADDR_ALT_B: rdByte = s_q.pinSync[1];
      ADDR_DATA_A, ADDR_DATA_B:
      begin
        idx = rdAddr == ADDR_DATA_B;
        src = (s_q.ctrl[idx][CTL_SUB_LSB +: 2] == SUB_IN) ? s_q.port[idx].final_input_latch : s_q.pinSync[idx];
        rdByte = (s_q.dir[idx] & s_q.port[idx].final_output_latch) | (~s_q.dir[idx] & src);
      end
      default: rdByte = REG_RESET;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.hsMeta = {handshakeBSecondIn, handshakeBFirst, handshakeASecondIn, handshakeAFirst};
    s_d.hsSync = s_q.hsMeta;
    s_d.hsPrev = asserted;
    s_d.pinMeta[0] = portAIn;
    s_d.pinMeta[1] = portBIn;
    s_d.pinSync = s_q.pinMeta;
    s_d.ackMeta = sharedC6AcknowledgePinN;
    s_d.ackSync = s_q.ackMeta;
    s_d.ackPrev = ~s_q.ackSync;
    s_d.wrPend = hsel && htrans[1] && hwrite && hready;
    s_d.wrAddr = haddr[7:0];
    if (addrRead)
    begin
      s_d.hrdata = {24'h000000, rdByte};
    end

    if (s_q.wrPend)
    begin
      unique case (s_q.wrAddr)
        ADDR_GENERAL: s_d.gen = wrByte;
        ADDR_REQUEST: s_d.req = wrByte;
        ADDR_VECTOR:
        begin
          s_d.vec = wrByte;
          s_d.vecInit = 1'b1;
        end
        ADDR_CTRL_A: s_d.ctrl[0] = wrByte;
        ADDR_CTRL_B: s_d.ctrl[1] = wrByte;
        ADDR_DIR_A: s_d.dir[0] = wrByte;
        ADDR_DIR_B: s_d.dir[1] = wrByte;
        default: s_d.req = s_d.req;
      endcase
    end

    for (int p = 0; p < 2; p++)
    begin
      logic en;
      logic [1:0] sub;
      logic [2:0] h2m;
      logic [3:0] mask;
      en = s_q.gen[GEN_EN_A + p];
      sub = s_q.ctrl[p][CTL_SUB_LSB +: 2];
      h2m = s_q.ctrl[p][CTL_H2_LSB +: 3];
      mask = statusWrite ? wrByte[3:0] : 4'h0;
      // Clear first so that an edge in the same cycle wins over the clear.
      if (mask[2 * p] && resettable[2 * p])
      begin
        s_d.port[p].h1sFlag = 1'b0;
      end
      if (mask[2 * p + 1] && resettable[2 * p + 1])
      begin
        s_d.port[p].h2sFlag = 1'b0;
      end
      if (sub[1] && edgeSeen[2 * p])
      begin
        s_d.port[p].h1sFlag = 1'b1;
      end
      if (isEdgeInput(h2m) && edgeSeen[2 * p + 1])
      begin
        s_d.port[p].h2sFlag = 1'b1;
      end
      if (h2Out[p] && isLinked(h2m))
      begin
        if (s_q.port[p].pulseCnt < PULSE_CYCLES)
        begin
          s_d.port[p].pulseCnt = s_q.port[p].pulseCnt + 3'h1;
        end
      end
      else if (!(h2m == H2_PULSED && s_q.port[p].pulseCnt == PULSE_CYCLES && s_q.port[p].cnt != CNT_EMPTY
                 && s_q.port[p].cnt != CNT_FULL && !edgeSeen[2 * p]))
      begin
        s_d.port[p].pulseCnt = 3'h0;
      end

      // Writes outside output submode land in the output latch, single-buffered.
      if (dataWrite[p] && sub != SUB_OUT)
      begin
        s_d.port[p].final_output_latch = wrByte;
      end
      if (sub == SUB_IN)
      begin
        if (dataRead[p])
        begin
          if (s_d.port[p].cnt == CNT_FULL)
          begin
            s_d.port[p].final_input_latch = s_q.port[p].iil;
            s_d.port[p].cnt = CNT_ONE;
          end
          else
          begin
            s_d.port[p].cnt = CNT_EMPTY;
          end
        end
        // Edges while both latches are full are ignored.
        if (en && edgeSeen[2 * p] && s_q.port[p].cnt != CNT_FULL)
        begin
          if (s_d.port[p].cnt == CNT_EMPTY)
          begin
            s_d.port[p].final_input_latch = s_q.pinSync[p];
            s_d.port[p].cnt = CNT_ONE;
          end
          else
          begin
            s_d.port[p].iil = s_q.pinSync[p];
            s_d.port[p].cnt = CNT_FULL;
          end
        end
      end
      else if (sub == SUB_OUT)
      begin
        if (en && edgeSeen[2 * p] && s_q.port[p].cnt != CNT_EMPTY)
        begin
          if (s_q.port[p].cnt == CNT_FULL)
          begin
            s_d.port[p].final_output_latch = s_q.port[p].initial_output_latch;
            s_d.port[p].cnt = CNT_ONE;
          end
          else
          begin
            s_d.port[p].cnt = CNT_EMPTY;
          end
        end
        if (dataWrite[p])
        begin
          if (s_d.port[p].cnt == CNT_EMPTY)
          begin
            s_d.port[p].final_output_latch = wrByte;
            s_d.port[p].cnt = CNT_ONE;
          end
          else if (s_d.port[p].cnt == CNT_ONE)
          begin
            s_d.port[p].initial_output_latch = wrByte;
            s_d.port[p].cnt = CNT_FULL;
          end
        end
      end
      else
      begin
        s_d.port[p].cnt = CNT_EMPTY;
      end
      if (!en)
      begin
        s_d.port[p].cnt = CNT_EMPTY;
        s_d.port[p].h1sFlag = 1'b0;
        s_d.port[p].h2sFlag = 1'b0;
        s_d.port[p].pulseCnt = 3'h0;
      end
    end

    if (port_dma_request)
    begin
      s_d.dmaPending = 1'b1;
    end
    else if ((dataRead[s_q.req[REQ_DMA_PORT]] || dataWrite[s_q.req[REQ_DMA_PORT]]) || !s_q.req[REQ_DMA_ON])
    begin
      s_d.dmaPending = 1'b0;
    end

    // The acknowledge touches only the vector output path, never the port state above.
    if (!s_q.ackSync && !s_q.ackPrev)
    begin
      if (s_q.req[REQ_ACK_SEL] && s_q.req[REQ_IRQ_SEL] && irqActive)
      begin
        s_d.ackActive = 1'b1;
        s_d.vecOut = s_q.vecInit ? {s_q.vec[7:2], prioCode} : VECTOR_UNINIT;
      end
    end
    else if (s_q.ackSync)
    begin
      s_d.ackActive = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    hrdata = s_q.hrdata;
    handshakeASecond.level = h2Out[0] ^ ~s_q.gen[1];
    handshakeASecond.oe = h2Oe[0];
    handshakeBSecond.level = h2Out[1] ^ ~s_q.gen[3];
    handshakeBSecond.oe = h2Oe[1];
    portAOut.data = s_q.port[0].final_output_latch;
    portAOut.oe = s_q.dir[0];
    portBOut.data = s_q.port[1].final_output_latch;
    portBOut.oe = s_q.dir[1];
    sharedC5InterruptPin = irqActive && s_q.req[REQ_IRQ_SEL];
    sharedC5InterruptOe = s_q.req[REQ_IRQ_SEL];
    sharedC4DmaPin = port_dma_request;
    sharedC4DmaOe = s_q.req[REQ_DMA_ON];
    vectorData = s_q.vecOut;
    vectorOe = s_q.ackActive;
    transferAck = s_q.ackActive;
  end

  logic [2:0] unusedSize;
  assign unusedSize = hsize;

endmodule : parallel_port_service_request

//--- bench/parallel_port_service_request_monitor.sv
// Concurrent checks on the service-request outputs of the parallel port block.
`timescale 1ns/100ps
module parallel_port_service_request_monitor
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sharedC5InterruptPin,
  input wire logic sharedC5InterruptOe,
  input wire logic sharedC4DmaPin,
  input wire logic sharedC4DmaOe,
  input wire logic sharedC6AcknowledgePinN,
  input wire logic [7:0] vectorData,
  input wire logic vectorOe,
  input wire logic transferAck
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_irq_needs_func: assert property (
    sharedC5InterruptPin |-> sharedC5InterruptOe) else $error("interrupt request without its pin function");
  a_dma_needs_func: assert property (
    sharedC4DmaPin |-> sharedC4DmaOe) else $error("dma request without its pin function");
  a_dma_one_pulse: assert property (
    sharedC4DmaPin |=> !sharedC4DmaPin) else $error("dma request longer than one cycle");
  a_ack_needs_irq: assert property (
    $rose(transferAck) |-> $past(sharedC5InterruptPin)) else $error("acknowledge answered without a request");
  // The acknowledge pin passes two sync stages and one register, so it was low three edges back.
  a_ack_after_pin: assert property (
    $rose(transferAck) |-> $past(!sharedC6AcknowledgePinN, 3)) else $error("answer without acknowledge pin");
  a_ack_release: assert property (
    sharedC6AcknowledgePinN [*5] |-> !transferAck) else $error("answer held after acknowledge ended");
  a_vector_with_ack: assert property (
    vectorOe == transferAck) else $error("vector drive and transfer acknowledge disagree");
  a_vector_steady: assert property (
    transferAck && $past(transferAck) |-> $stable(vectorData)) else $error("vector changed during acknowledge");

  cover property ($rose(transferAck));
  cover property (transferAck && vectorData == 8'h0F);
  cover property (sharedC5InterruptPin ##1 !sharedC5InterruptPin);
  cover property (sharedC4DmaPin);
endmodule : parallel_port_service_request_monitor

bind parallel_port_service_request parallel_port_service_request_monitor u_monitor (.mclk, .sys_rst,
  .sharedC5InterruptPin, .sharedC5InterruptOe, .sharedC4DmaPin, .sharedC4DmaOe,
  .sharedC6AcknowledgePinN, .vectorData, .vectorOe, .transferAck);

//--- bench/handshake_peripheral.sv
// Peripheral model that asserts the four handshake inputs on command.
`timescale 1ns/100ps
module handshake_peripheral
(
  input wire logic mclk,
  input wire logic [3:0] strike,
  input wire logic [3:0] sense,
  output logic [3:0] pins
);
  logic [2:0] left [4] = '{default: 3'h0};

  // Each assertion lasts four cycles so that the two sync stages always see it.
  always @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (strike[i])
        left[i] <= 3'h4;
      else if (left[i] != 3'h0)
        left[i] <= left[i] - 3'h1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pins[i] = (left[i] != 3'h0) ? sense[i] : ~sense[i];
  end
endmodule : handshake_peripheral

//--- bench/parallel_port_service_request_tb_top.sv
// Self-checking bench for the parallel port service-request block.
`timescale 1ns/100ps
module parallel_port_service_request_tb_top
  import parallel_port_pkg::*;
;
  logic mclk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, ackPinN = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0] portAIn = 8'hA5, portBIn = 8'h5A, vecData;
  logic [3:0] strike = 4'h0, modelSense = 4'h0, pins;
  logic hreadyout, hresp, irq, irqOe, dma, dmaOe, vecOe, tack;
  pinDrive_t secA, secB;
  portDrive_t outA, outB;
  int nErrors = 0, checksDone = 0, cycles = 0;
  logic [7:0] dmaCount = 8'h00;

  always #12.5 mclk = ~mclk;

  handshake_peripheral u_peripheral (.mclk(mclk), .strike(strike), .sense(modelSense), .pins(pins));

  parallel_port_service_request u_dut (.mclk(mclk), .sys_rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .handshakeAFirst(pins[0]),
    .handshakeASecondIn(secA.oe ? secA.level : pins[1]), .handshakeASecond(secA),
    .handshakeBFirst(pins[2]), .handshakeBSecondIn(secB.oe ? secB.level : pins[3]),
    .handshakeBSecond(secB), .portAIn(portAIn), .portAOut(outA), .portBIn(portBIn), .portBOut(outB),
    .sharedC5InterruptPin(irq), .sharedC5InterruptOe(irqOe), .sharedC4DmaPin(dma),
    .sharedC4DmaOe(dmaOe), .sharedC6AcknowledgePinN(ackPinN), .vectorData(vecData),
    .vectorOe(vecOe), .transferAck(tack));

  task automatic end_of_test;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      nErrors++;
      end_of_test();
    end
  end

  // The request is a one-cycle pulse, so it is counted at every edge rather than polled.
  always @(posedge mclk)
  begin
    if (dma === 1'h1)
    begin
      dmaCount <= dmaCount + 8'h01;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One AHB single transfer; the data phase ends at the edge where hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge mclk);
    hsel <= 1'h1;
    haddr <= {24'h0, addr};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wdata};
    do @(posedge mclk); while (hreadyout !== 1'h1);
    rdata = hrdata[7:0];
    hsel <= 1'h0;
  endtask : bus

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    bus(1'h1, addr, data, unused);
  endtask : wr

  task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    bus(1'h0, addr, 8'h00, got);
    chk(got, exp);
  endtask : rdChk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic pulse(input int i);
    @(posedge mclk);
    strike <= 4'h1 << i;
    @(posedge mclk);
    strike <= 4'h0;
    settle(8);
  endtask : pulse

  task automatic ack(input logic answered, input logic [7:0] expVec);
    @(posedge mclk);
    ackPinN <= 1'h0;
    for (int i = 0; i < 8 && tack !== 1'h1; i++)
      @(posedge mclk);
    #1;
    chk({7'h0, tack}, {7'h0, answered});
    if (answered)
      chk(vecData, expVec);
    @(posedge mclk);
    ackPinN <= 1'h1;
    for (int i = 0; i < 8 && tack !== 1'h0; i++)
      @(posedge mclk);
    settle(3);
  endtask : ack

  task automatic t_levels;
    wr(ADDR_GENERAL, 8'h0F);
    settle(4);
    rdChk(ADDR_STATUS, 8'hF0);
    wr(ADDR_GENERAL, 8'h00);
    settle(4);
    rdChk(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL_A, 8'h86);
    pulse(0);
    rdChk(ADDR_STATUS, 8'h00);
  endtask : t_levels

  task automatic t_clear;
    wr(ADDR_GENERAL, 8'h30);
    pulse(0);
    rdChk(ADDR_STATUS, 8'h01);
    wr(ADDR_STATUS, 8'h0E);
    rdChk(ADDR_STATUS, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    rdChk(ADDR_STATUS, 8'h00);
  endtask : t_clear

  task automatic t_vectors;
    wr(ADDR_CTRL_B, 8'h86);
    wr(ADDR_REQUEST, 8'h03);
    pulse(3);
    chk({6'h0, irqOe, irq}, 8'h03);
    ack(1'h1, VECTOR_UNINIT);
    wr(ADDR_STATUS, 8'h08);
    wr(ADDR_VECTOR, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      pulse(i);
      ack(1'h1, 8'h40 | 8'(i));
      rdChk(ADDR_STATUS, 8'h1 << i);
      wr(ADDR_STATUS, 8'h1 << i);
      settle(2);
      chk({7'h0, irq}, 8'h00);
    end
    pulse(3);
    pulse(1);
    ack(1'h1, 8'h41);
    wr(ADDR_STATUS, 8'h0A);
  endtask : t_vectors

  task automatic t_noAnswer;
    wr(ADDR_REQUEST, 8'h03);
    ack(1'h0, 8'h00);
    wr(ADDR_REQUEST, 8'h02);
    pulse(0);
    chk({6'h0, irqOe, irq}, 8'h00);
    ack(1'h0, 8'h00);
    wr(ADDR_REQUEST, 8'h01);
    settle(2);
    chk({6'h0, irqOe, irq}, 8'h03);
    ack(1'h0, 8'h00);
    wr(ADDR_STATUS, 8'h01);
  endtask : t_noAnswer

  task automatic t_secondPin;
    wr(ADDR_GENERAL, 8'h00);
    wr(ADDR_CTRL_A, 8'h30);
    settle(2);
    chk({6'h0, secA.oe, secA.level}, 8'h03);
    wr(ADDR_GENERAL, 8'h10);
    settle(8);
    chk({6'h0, secA.oe, secA.level}, 8'h02);
  endtask : t_secondPin

  task automatic t_paths;
    rdChk(ADDR_ALT_A, 8'hA5);
    rdChk(ADDR_ALT_B, 8'h5A);
    wr(ADDR_CTRL_A, 8'h80);
    wr(ADDR_DIR_A, 8'h0F);
    wr(ADDR_DATA_A, 8'h3C);
    settle(1);
    chk(outA.data, 8'h3C);
    chk(outA.oe, 8'h0F);
    rdChk(ADDR_DATA_A, 8'hAC);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_DIR_A, 8'hFF);
    rdChk(ADDR_DATA_A, 8'h3C);
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_DIR_A, 8'h00);
    rdChk(ADDR_DATA_A, 8'hA5);
  endtask : t_paths

  // DMA on the port A first pin: one request per service need, re-armed by each data read.
  task automatic t_dma;
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_REQUEST, 8'h04);
    @(posedge mclk);
    portAIn <= 8'h11;
    pulse(0);
    pulse(2);
    rdChk(ADDR_STATUS, 8'h01);
    @(posedge mclk);
    portAIn <= 8'h22;
    pulse(0);
    chk({dmaOe, dmaCount[6:0]}, 8'h81);
    rdChk(ADDR_DATA_A, 8'h11);
    rdChk(ADDR_DATA_A, 8'h22);
    settle(2);
    chk({dmaOe, dmaCount[6:0]}, 8'h82);
    chk({7'h0, hresp}, 8'h00);
    pulse(0);
    wr(ADDR_GENERAL, 8'h00);
    rdChk(ADDR_STATUS, 8'h00);
    wr(ADDR_REQUEST, 8'h00);
    settle(1);
    chk({dmaOe, dmaCount[6:0]}, 8'h03);
  endtask : t_dma

  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    rdChk(ADDR_GENERAL, 8'h00);
    rdChk(ADDR_VECTOR, VECTOR_UNINIT);
    rdChk(8'h3C, 8'h00);
    t_levels();
    t_clear();
    t_vectors();
    t_noAnswer();
    t_secondPin();
    t_paths();
    t_dma();
    end_of_test();
  end
endmodule : parallel_port_service_request_tb_top
